// ===== boot_pkg.sv
// Shared constants and carrier types for the reset-time boot mode selector.
package boot_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  // Positions of the two boot configuration bits in the low configuration port.
  localparam int CFG_PORT_W = 8;
  localparam int CFG_BIT_HI = 5;
  localparam int CFG_BIT_LO = 4;
  // Decoded boot configuration patterns.
  localparam logic [1:0] MODE_USER = 2'h3;
  localparam logic [1:0] MODE_STD = 2'h2;
  localparam logic [1:0] MODE_SEL = 2'h1;
  localparam logic [1:0] MODE_RSVD = 2'h0;
  localparam logic [1:0] MODE_RESET_VAL = MODE_RSVD;
  // Code is fetched from this base in every mode; only the source changes.
  localparam logic [ADDR_W-1:0] USER_FLASH_BASE = 24'h000000;
  // Flash locations holding the signature pair and the user key.
  localparam logic [ADDR_W-1:0] SIG_ADDR0 = 24'h03fff8;
  localparam logic [ADDR_W-1:0] SIG_ADDR1 = 24'h03fffa;
  localparam logic [ADDR_W-1:0] KEY_ADDR = 24'h03fffc;
  localparam logic [DATA_W-1:0] SIG_REF = 16'ha55a;
  // User key values; any other value parks the device in an endless loop.
  localparam logic [DATA_W-1:0] KEY_STD = 16'h0001;
  localparam logic [DATA_W-1:0] KEY_UART = 16'h0002;
  localparam logic [DATA_W-1:0] KEY_CAN = 16'h0003;
  // Line qualification times and the cycle counts at the 100 ns clock.
  localparam int CLK_PERIOD_NS = 100;
  localparam int UART_START_NS = 100;
  localparam int CAN_DOM_NS = 500;
  localparam int UART_START_CYC = (UART_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAN_DOM_CYC = (CAN_DOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic rd;
    logic [ADDR_W-1:0] addr;
  } flash_req_t;

  typedef struct packed {
    logic user_run;
    logic test_fetch;
    logic uart_boot;
    logic can_boot;
    logic halt;
  } boot_path_t;
endpackage

// ===== line_watch.sv
// Detects a receive line going low for a minimum time after it was seen idle high.
`timescale 1ns/10ps
module line_watch #(
  parameter int MIN_LOW = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic line,
  output logic detect
);
  localparam int CNT_W = $clog2(MIN_LOW + 1);
  logic armed;
  logic [CNT_W-1:0] low_cnt;
  wire low_done = (low_cnt == CNT_W'(MIN_LOW - 1));

  initial begin
    if (MIN_LOW < 1) $error("line_watch: MIN_LOW must be at least 1");
  end

  // A line that is low when polling begins is not a start: it must idle first.
  always_ff @(posedge clk) begin
    if (!rst_b || !enable) begin
      armed <= 1'b0;
      low_cnt <= '0;
      detect <= 1'b0;
    end else if (line) begin
      armed <= 1'b1;
      low_cnt <= '0;
    end else if (armed && !detect) begin
      detect <= low_done;
      low_cnt <= low_done ? low_cnt : low_cnt + CNT_W'(1);
    end
  end
endmodule

// ===== boot_mode_selector.sv
// Reset-time boot mode selection, selective boot checks and loader channel polling.
`timescale 1ns/10ps
// How it works
// - Boot bits 5..4 latched at reset release.
// - Pattern 11 runs user code from zero.
// - Pattern 10 overlays test flash for fetches.
// - Pattern 01: valid signature, software reset, user.
// - Invalid signature: user key picks four outcomes.
// - Signature from two words against reference.
// - Loader polls UART and CAN receive lines.
// - UART start first selects UART loader.
// - CAN dominant first selects CAN loader.
module boot_mode_selector
  import boot_pkg::*;
#(
  parameter int UART_MIN_LOW = UART_START_CYC,
  parameter int CAN_MIN_LOW = CAN_DOM_CYC
) (
  // Clock and external reset input
  input wire logic CLK,
  input wire logic RST_B,
  // Configuration port and receive pins
  input wire logic [CFG_PORT_W-1:0] BOOT_CONFIG_PORT_LOW,
  input wire logic UART0_RECEIVE_LINE,
  input wire logic CAN1_RECEIVE_LINE,
  // Flash read port
  output flash_req_t FLASH_REQ,
  input wire logic FLASH_VALID,
  input wire logic [DATA_W-1:0] FLASH_DATA,
  // Boot decision
  output logic [1:0] BOOT_MODE,
  output boot_path_t BOOT_PATH,
  output logic SW_RESET,
  output logic [ADDR_W-1:0] FETCH_BASE
);
  typedef enum logic [11:0] {
    S_RESET = 12'h001,
    S_USER = 12'h002,
    S_SIG_RD0 = 12'h004,
    S_SIG_RD1 = 12'h008,
    S_KEY_RD = 12'h010,
    S_SWRST = 12'h020,
    S_POLL = 12'h040,
    S_UART = 12'h080,
    S_CAN = 12'h100,
    S_LOOP = 12'h200,
    S_RSVD = 12'h400,
    S_STD_INIT = 12'h800
  } state_t;

  state_t state, next_state;
  logic [1:0] cfg_meta, cfg_sync;
  logic [1:0] rx_meta, rx_sync;
  logic [DATA_W-1:0] sig_word0;
  logic poll_uart, poll_can, next_poll_uart, next_poll_can;
  logic uart_det, can_det;

  initial begin
    if (UART_MIN_LOW < 1 || CAN_MIN_LOW < 1) $error("boot_mode_selector: bad line times");
  end

  // Pins are asynchronous to CLK; each passes two flip-flops before use.
  always_ff @(posedge CLK) begin
    cfg_meta <= {BOOT_CONFIG_PORT_LOW[CFG_BIT_HI], BOOT_CONFIG_PORT_LOW[CFG_BIT_LO]};
    cfg_sync <= cfg_meta;
    rx_meta <= {UART0_RECEIVE_LINE, CAN1_RECEIVE_LINE};
    rx_sync <= rx_meta;
  end

  // Key decode: maps a key word to its loader outcome state.
  function automatic state_t key_target(input logic [DATA_W-1:0] key);
    if (key == KEY_STD) return S_STD_INIT;
    else if (key == KEY_UART) return S_STD_INIT;
    else if (key == KEY_CAN) return S_STD_INIT;
    else return S_LOOP;
  endfunction

  // Mode decode: first state after the configuration has been latched.
  function automatic state_t mode_target(input logic [1:0] mode);
    unique case (mode)
      MODE_USER: return S_USER;
      MODE_STD: return S_STD_INIT;
      MODE_SEL: return S_SIG_RD0;
      default: return S_RSVD;
    endcase
  endfunction

  wire capture = (state == S_RESET);
  wire flash_done = FLASH_VALID && FLASH_REQ.rd;
  wire [DATA_W-1:0] sig_sum = DATA_W'(sig_word0 + FLASH_DATA);
  wire sig_ok = (sig_sum == SIG_REF);
  wire uart_first = poll_uart && uart_det;
  wire can_first = poll_can && can_det && !uart_first;

  line_watch #(.MIN_LOW(UART_MIN_LOW)) u_uart_watch (
    .clk(CLK),
    .rst_b(RST_B),
    .enable(state == S_POLL && poll_uart),
    .line(rx_sync[1]),
    .detect(uart_det)
  );

  line_watch #(.MIN_LOW(CAN_MIN_LOW)) u_can_watch (
    .clk(CLK),
    .rst_b(RST_B),
    .enable(state == S_POLL && poll_can),
    .line(rx_sync[0]),
    .detect(can_det)
  );

  always_comb begin
    next_state = state;
    next_poll_uart = poll_uart;
    next_poll_can = poll_can;
    unique case (state)
      S_RESET: next_state = mode_target(cfg_sync);
      S_STD_INIT: next_state = S_POLL;
      S_SIG_RD0: if (flash_done) next_state = S_SIG_RD1;
      S_SIG_RD1: if (flash_done) next_state = sig_ok ? S_SWRST : S_KEY_RD;
      S_KEY_RD: if (flash_done) next_state = key_target(FLASH_DATA);
      S_SWRST: next_state = S_USER;
      S_POLL: begin
        if (uart_first) next_state = S_UART;
        else if (can_first) next_state = S_CAN;
      end
      default: next_state = state;
    endcase
    // Channel enables: both for the standard loader, one for key-limited loaders.
    if (state == S_RESET) begin
      next_poll_uart = 1'b1;
      next_poll_can = 1'b1;
    end else if (state == S_KEY_RD && flash_done) begin
      next_poll_uart = (FLASH_DATA != KEY_CAN);
      next_poll_can = (FLASH_DATA != KEY_UART);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state <= S_RESET;
      BOOT_MODE <= MODE_RESET_VAL;
      poll_uart <= 1'b0;
      poll_can <= 1'b0;
      sig_word0 <= '0;
    end else begin
      state <= next_state;
      poll_uart <= next_poll_uart;
      poll_can <= next_poll_can;
      if (capture) BOOT_MODE <= cfg_sync;
      if (state == S_SIG_RD0 && flash_done) sig_word0 <= FLASH_DATA;
    end
  end

  // Outputs are registered from the next state so they line up with the state register.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      BOOT_PATH <= '0;
      SW_RESET <= 1'b0;
      FETCH_BASE <= USER_FLASH_BASE;
      FLASH_REQ <= '0;
    end else begin
      BOOT_PATH.user_run <= (next_state == S_USER);
      BOOT_PATH.test_fetch <= !(next_state inside {S_RESET, S_USER, S_RSVD});
      BOOT_PATH.uart_boot <= (next_state == S_UART);
      BOOT_PATH.can_boot <= (next_state == S_CAN);
      BOOT_PATH.halt <= (next_state inside {S_LOOP, S_RSVD});
      SW_RESET <= (next_state == S_SWRST);
      FETCH_BASE <= USER_FLASH_BASE;
      FLASH_REQ.rd <= (next_state inside {S_SIG_RD0, S_SIG_RD1, S_KEY_RD}) && !flash_done;
      FLASH_REQ.addr <= (next_state == S_SIG_RD0) ? SIG_ADDR0 :
                        (next_state == S_SIG_RD1) ? SIG_ADDR1 : KEY_ADDR;
    end
  end

  sequence sel_soft_reset;
    state == S_SWRST ##1 state == S_USER;
  endsequence

  a_mode_capture: assert property (@(posedge CLK) disable iff (!RST_B)
    capture |=> BOOT_MODE == $past(cfg_sync)) else $error("boot mode not latched");
  a_mode_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    (!capture && $past(RST_B)) |=> $stable(BOOT_MODE)) else $error("boot mode moved");
  a_user_map: assert property (@(posedge CLK) disable iff (!RST_B)
    state == S_USER |-> BOOT_PATH.user_run && !BOOT_PATH.test_fetch
    && FETCH_BASE == USER_FLASH_BASE) else $error("user mode map wrong");
  a_std_overlay: assert property (@(posedge CLK) disable iff (!RST_B)
    (capture && cfg_sync == MODE_STD) |=> state == S_STD_INIT ##1
    (state == S_POLL && BOOT_PATH.test_fetch && poll_uart && poll_can))
    else $error("standard loader entry wrong");
  a_sel_valid: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == S_SIG_RD1 && flash_done && sig_ok) |=> SW_RESET ##0 sel_soft_reset)
    else $error("valid signature did not reset to user");
  // The read strobe drops for one cycle after each accepted word before the key read.
  a_sig_invalid: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == S_SIG_RD1 && flash_done && !sig_ok) |=> state == S_KEY_RD
    && !FLASH_REQ.rd && FLASH_REQ.addr == KEY_ADDR ##1 FLASH_REQ.rd)
    else $error("invalid signature did not read key");
  a_key_outcome: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == S_KEY_RD && flash_done) |=> state == key_target($past(FLASH_DATA)))
    else $error("key outcome wrong");
  a_uart_first: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == S_POLL && uart_first) |=> state == S_UART ##1 BOOT_PATH.uart_boot)
    else $error("UART start not taken");
  a_can_first: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == S_POLL && can_first) |=> state == S_CAN && !BOOT_PATH.uart_boot)
    else $error("CAN dominant not taken");
  a_poll_lines: assert property (@(posedge CLK) disable iff (!RST_B)
    state == S_POLL |-> (poll_uart || poll_can) && !BOOT_PATH.user_run)
    else $error("polling with no channel");
endmodule

// ===== boot_flash_model.sv
// Flash partner that answers the selector's reads after a chosen latency.
`timescale 1ns/10ps
module boot_flash_model
  import boot_pkg::*;
(
  // Clock and request
  input wire logic clk,
  input wire flash_req_t req,
  // Latency and stored words set by the bench
  input wire logic [3:0] delay,
  input wire logic [DATA_W-1:0] word0,
  input wire logic [DATA_W-1:0] word1,
  input wire logic [DATA_W-1:0] key,
  // Answer
  output logic valid,
  output logic [DATA_W-1:0] data
);
  logic [3:0] cnt = 4'h0;
  logic [DATA_W-1:0] last = 16'h0;
  wire logic [DATA_W-1:0] word = (req.addr == SIG_ADDR0) ? word0 :
    (req.addr == SIG_ADDR1) ? word1 : (req.addr == KEY_ADDR) ? key : ~last;
  initial begin
    valid = 1'b0;
    data = 16'h0;
  end
  // Outside an answer the bus shows the inverse of the last word, so stale data never matches.
  always @(negedge clk) begin
    if (valid || !req.rd) begin
      valid <= 1'b0;
      data <= ~last;
      cnt <= 4'h0;
    end else if (cnt >= delay) begin
      valid <= 1'b1;
      data <= word;
      last <= word;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ===== boot_mode_selector_tb.sv
// Self-checking bench for the boot mode selector with a flash partner.
`timescale 1ns/10ps
module boot_mode_selector_tb;
  import boot_pkg::*;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [CFG_PORT_W-1:0] cfg = 8'hff;
  logic rxu = 1'b1;
  logic rxc = 1'b1;
  logic [3:0] dly = 4'h1;
  logic [DATA_W-1:0] w0 = 16'h0, w1 = 16'h0, key = 16'h0;
  flash_req_t req;
  logic fv;
  logic [DATA_W-1:0] fd;
  logic [1:0] mode;
  boot_path_t path;
  logic swr;
  logic [ADDR_W-1:0] base;
  int n_mismatch = 0;
  int n_checks = 0;
  always #50 CLK = ~CLK;
  boot_mode_selector dut (.CLK(CLK), .RST_B(RST_B), .BOOT_CONFIG_PORT_LOW(cfg),
    .UART0_RECEIVE_LINE(rxu), .CAN1_RECEIVE_LINE(rxc), .FLASH_REQ(req), .FLASH_VALID(fv),
    .FLASH_DATA(fd), .BOOT_MODE(mode), .BOOT_PATH(path), .SW_RESET(swr), .FETCH_BASE(base));
  boot_flash_model flash (.clk(CLK), .req(req), .delay(dly), .word0(w0), .word1(w1),
    .key(key), .valid(fv), .data(fd));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic flag(input int which);
    case (which)
      0: return swr;
      1: return path.uart_boot;
      default: return path.can_boot;
    endcase
  endfunction
  task automatic await(input int which, input int lim);
    int i;
    for (i = 0; i < lim && flag(which) !== 1'b1; i++) @(negedge CLK);
    if (i == lim) begin
      n_mismatch++;
      $display("unexpected wait %0d: expected 1 seen 0", which);
      print_verdict();
    end
  endtask
  // Unused lines rest high during every reset, as the host must keep them.
  task automatic boot(input logic [1:0] pins);
    RST_B = 1'b0;
    cfg = {2'h3, pins, 4'hf};
    rxu = 1'b1;
    rxc = 1'b1;
    repeat (3) @(negedge CLK);
    RST_B = 1'b1;
    repeat (4) @(negedge CLK);
    check("mode", pins, mode);
  endtask
  task automatic drop(input logic can, input int n);
    if (can) rxc = 1'b0;
    else rxu = 1'b0;
    repeat (n) @(negedge CLK);
    rxc = 1'b1;
    rxu = 1'b1;
  endtask
  task automatic sc_user();
    boot(2'h3);
    check("user_run", 1, path.user_run);
    check("fetch_base", USER_FLASH_BASE, base);
    cfg = 8'h00;
    repeat (5) @(negedge CLK);
    check("mode held", MODE_USER, mode);
    check("flash rd", 0, req.rd);
  endtask
  // A dominant glitch shorter than the qualification time must not start the CAN loader.
  task automatic sc_std();
    boot(2'h2);
    check("test_fetch", 1, path.test_fetch);
    drop(1'b1, 3);
    repeat (10) @(negedge CLK);
    check("can glitch", 0, path.can_boot);
    drop(1'b1, 8);
    await(2, 20);
    check("uart after can", 0, path.uart_boot);
    boot(2'h2);
    drop(1'b0, 2);
    await(1, 20);
    drop(1'b1, 8);
    check("can after uart", 0, path.can_boot);
  endtask
  task automatic sc_sel_ok();
    dly = 4'h3;
    w0 = 16'hffff;
    w1 = 16'ha55b;
    boot(2'h1);
    await(0, 40);
    @(negedge CLK);
    check("sw_reset width", 0, swr);
    check("user_run", 1, path.user_run);
  endtask
  task automatic sc_keys();
    logic [DATA_W-1:0] keys [4] = '{KEY_STD, KEY_UART, KEY_CAN, 16'h0004};
    dly = 4'h0;
    w0 = 16'h1234;
    w1 = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      key = keys[k];
      boot(2'h1);
      repeat (20) @(negedge CLK);
      check("halt", k == 3, path.halt);
      drop(1'b1, 8);
      repeat (10) @(negedge CLK);
      check("can loader", k == 0 || k == 2, path.can_boot);
      drop(1'b0, 2);
      repeat (10) @(negedge CLK);
      check("uart loader", k == 1, path.uart_boot);
    end
  endtask
  initial begin
    repeat (2) @(negedge CLK);
    sc_user();
    sc_std();
    sc_sel_ok();
    sc_keys();
    boot(2'h0);
    check("reserved halt", 1, path.halt);
    print_verdict();
  end
endmodule
